// ==== bench/frit_cpu_model.sv ====
// Wishbone master model that stands in for the CPU core.
`timescale 1ns/1ps
`default_nettype none
module frit_cpu_model
    import frit_pkg::*;
(
    input wire logic clk_i,
    input wire frit_wb_rsp_t wb_i,
    output var frit_wb_req_t wb_o
);
    initial wb_o = '0;

    // One classic cycle; an edge passes first, so cyc stays low between cycles.
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [7:0] wd,
        output logic [7:0] rd);
        @(posedge clk_i);
        wb_o <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h1, dat: {24'h0, wd}};
        do @(posedge clk_i); while (wb_i.ack !== 1'b1);
        rd = wb_i.dat[7:0];
        wb_o <= '0;
    endtask

    // The low byte always goes first, or the pair would not land as one value.
    task automatic wr_pair(input logic [7:0] adr, input logic [7:0] lo, hi);
        logic [7:0] d;
        xfer(1'b1, adr, lo, d);
        xfer(1'b1, adr + 8'h04, hi, d);
    endtask

    // Reads in the same order, so for a counter the high byte comes from the holding register.
    task automatic rd_pair(input logic [7:0] adr, output logic [7:0] lo, hi);
        xfer(1'b0, adr, 8'h00, lo);
        xfer(1'b0, adr + 8'h04, 8'h00, hi);
    endtask
endmodule
`default_nettype wire

// ==== bench/frit_timer_tb.sv ====
// Self-checking bench for the free-running and interval timer.
`timescale 1ns/1ps
`default_nettype none
module frit_timer_tb
    import frit_pkg::*;
;
    localparam int TP = 16;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [2:0] irq_take_i = 3'h0;
    frit_wb_req_t wb_req;
    frit_wb_rsp_t wb_rsp;
    logic [2:0] irq_req_o;
    logic [7:0] irq_vec_o;
    logic [7:0] lo, hi, d;
    int n_mismatch = 0;
    int n_tests = 0;
    int n;

    // System clock of 125 MHz.
    always #4 clk_i = ~clk_i;

    // A short tick period keeps the periodic request test brief.
    frit_timer #(.TICK_PERIOD(TP)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_req),
        .wb_o(wb_rsp), .irq_take_i(irq_take_i), .irq_req_o(irq_req_o), .irq_vec_o(irq_vec_o));
    frit_cpu_model cpu_u (.clk_i(clk_i), .wb_i(wb_rsp), .wb_o(wb_req));

    task automatic chk(input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input logic [31:0] got, lo_b, hi_b);
        n_tests++;
        if ($isunknown(got) || got < lo_b || got > hi_b)
        begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h..%h", $time, got, lo_b, hi_b);
        end
    endtask

    task automatic complete_run();
        if (n_mismatch == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Waits for a posted request; the bound catches a source that never fires.
    task automatic wait_set(input int b, output int c);
        c = 0;
        while (irq_req_o[b] !== 1'b1 && c < 30000)
        begin
            @(posedge clk_i);
            c++;
        end
        chk_rng(c, 0, 29999);
    endtask

    // Clears one request through the take strobe; three edges pass.
    task automatic take(input int b);
        @(posedge clk_i);
        irq_take_i <= 3'(1 << b);
        @(posedge clk_i);
        irq_take_i <= 3'h0;
        @(posedge clk_i);
    endtask

    task automatic t_reset();
        logic [7:0] ra [4];
        ra = '{IVL_RLD_LOW_ADR, IVL_RLD_HIGH_ADR, IVL_CNT_HIGH_ADR, 8'hfc};
        chk({irq_req_o, irq_vec_o}, 32'h0);
        foreach (ra[i])
        begin
            cpu_u.xfer(1'b0, ra[i], 8'h00, d);
            chk(d, BYTE_RST);
        end
    endtask

    // Count read pair, then one full reload period measured in cycles.
    task automatic t_ivl();
        cpu_u.wr_pair(IVL_RLD_LOW_ADR, 8'h05, 8'h03);
        repeat (80) @(posedge clk_i);
        cpu_u.rd_pair(IVL_CNT_LOW_ADR, lo, hi);
        chk_rng(lo, 32'h03, 32'h05);
        chk(hi, 32'h03);
        cpu_u.rd_pair(IVL_RLD_LOW_ADR, lo, hi);
        chk({hi, lo}, 32'h0305);
        take(IRQ_IVL);
        wait_set(IRQ_IVL, n);
        chk(irq_vec_o, irq_req_o[IRQ_TICK] ? VEC_TICK : VEC_IVL);
        take(IRQ_IVL);
        wait_set(IRQ_IVL, n);
        chk_rng(n + 3, 32'h306 * 31, 32'h306 * 32);
    endtask

    // Atomic pairs on the free counter, with a stray low-byte write.
    task automatic t_free();
        cpu_u.wr_pair(FREE_LOW_ADR, 8'hfe, 8'h12);
        cpu_u.xfer(1'b0, FREE_LOW_ADR, 8'h00, lo);
        repeat (200) @(posedge clk_i);
        cpu_u.xfer(1'b0, FREE_HIGH_ADR, 8'h00, hi);
        chk_rng(lo, 32'hfe, 32'hff);
        chk(hi, 32'h12);
        cpu_u.xfer(1'b1, FREE_LOW_ADR, 8'h00, d);
        cpu_u.rd_pair(FREE_LOW_ADR, lo, hi);
        chk_rng(lo, 32'h03, 32'h0a);
        chk(hi, 32'h13);
    endtask

    // Wrap request, priority against the tick, take and write-one-to-clear.
    task automatic t_wrap();
        cpu_u.wr_pair(FREE_LOW_ADR, 8'hf8, 8'hff);
        cpu_u.xfer(1'b1, IRQ_STAT_ADR, 8'h07, d);
        wait_set(IRQ_WRAP, n);
        chk({irq_req_o, irq_vec_o}, {3'b101, VEC_TICK});
        take(IRQ_TICK);
        chk({irq_req_o, irq_vec_o}, {3'b100, VEC_WRAP});
        cpu_u.rd_pair(FREE_LOW_ADR, lo, hi);
        chk_rng({hi, lo}, 32'h0, 32'h1);
        cpu_u.xfer(1'b0, IRQ_STAT_ADR, 8'h00, d);
        chk(d, 32'h04);
        cpu_u.xfer(1'b1, IRQ_STAT_ADR, 8'h04, d);
        @(posedge clk_i);
        chk({irq_req_o, irq_vec_o}, 32'h0);
    endtask

    task automatic t_tick();
        take(IRQ_TICK);
        wait_set(IRQ_TICK, n);
        take(IRQ_TICK);
        wait_set(IRQ_TICK, n);
        chk_rng(n + 3, TP * 31, TP * 32);
    endtask

    // Main sequence after an eight-cycle reset.
    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_ivl();
        t_free();
        t_wrap();
        t_tick();
        complete_run();
    end

    // Watchdog well beyond the two interval periods that dominate the run.
    initial
    begin
        repeat (80000) @(posedge clk_i);
        n_mismatch++;
        complete_run();
    end
endmodule
`default_nettype wire

// ==== shared/frit_pkg.sv ====
// Constants, register map and carrier types of the free-running and interval timer.
package frit_pkg;

    // System clock and timer base rates in MHz.
    localparam int CLK_MHZ = 125;
    localparam int TMR_MHZ = 4;
    localparam logic [7:0] ACC_STEP = 8'(TMR_MHZ);
    localparam logic [7:0] ACC_MOD = 8'(CLK_MHZ);

    // Register indices; the byte address on the bus is four times the index.
    localparam int FREE_LOW_IDX = 'h20;
    localparam int FREE_HIGH_IDX = 'h21;
    localparam int IVL_CNT_LOW_IDX = 'h26;
    localparam int IVL_CNT_HIGH_IDX = 'h27;
    localparam int IVL_RLD_LOW_IDX = 'h28;
    localparam int IVL_RLD_HIGH_IDX = 'h29;
    localparam int IRQ_STAT_IDX = 'h2a;
    localparam logic [7:0] FREE_LOW_ADR = 8'(FREE_LOW_IDX * 4);
    localparam logic [7:0] FREE_HIGH_ADR = 8'(FREE_HIGH_IDX * 4);
    localparam logic [7:0] IVL_CNT_LOW_ADR = 8'(IVL_CNT_LOW_IDX * 4);
    localparam logic [7:0] IVL_CNT_HIGH_ADR = 8'(IVL_CNT_HIGH_IDX * 4);
    localparam logic [7:0] IVL_RLD_LOW_ADR = 8'(IVL_RLD_LOW_IDX * 4);
    localparam logic [7:0] IVL_RLD_HIGH_ADR = 8'(IVL_RLD_HIGH_IDX * 4);
    localparam logic [7:0] IRQ_STAT_ADR = 8'(IRQ_STAT_IDX * 4);

    // Reset values of all registers.
    localparam logic [15:0] FREE_RST = 16'h0000;
    localparam logic [11:0] IVL_RST = 12'h000;
    localparam logic [7:0] BYTE_RST = 8'h00;

    // Timing: periodic tick and counter wrap, in microseconds and timer ticks.
    localparam int TICK_US = 1024;
    localparam int TICK_TICKS = TICK_US * TMR_MHZ;
    localparam int WRAP_US = 16384;
    localparam logic [15:0] FREE_MAX = 16'hffff;

    // Interrupt request bit positions and their vectors.
    localparam int IRQ_TICK = 0;
    localparam int IRQ_IVL = 1;
    localparam int IRQ_WRAP = 2;
    localparam logic [7:0] VEC_NONE = 8'h00;
    localparam logic [7:0] VEC_TICK = 8'h34;
    localparam logic [7:0] VEC_IVL = 8'h38;
    localparam logic [7:0] VEC_WRAP = 8'h44;

    // Wishbone request from the master.
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } frit_wb_req_t;

    // Wishbone answer from the slave.
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } frit_wb_rsp_t;

endpackage

// ==== verilog/frit_timer.sv ====
// Free-running 16-bit counter and 12-bit interval timer behind a Wishbone slave.
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - A 16-bit free-running counter advances on a 4 MHz timer tick, readable as a time base.
// - Reading the counter low byte copies its high byte into a holding register read later.
// - The read sample of the counter is taken in the cycle of the low-byte read.
// - A low-byte write is held and all 16 bits load only when the high byte is written.
// - The free-running timer posts a periodic request every 1024 microseconds.
// - The counter posts a separate wrap request on each overflow, every 16.384 ms.
// - The 12-bit interval count is readable and a low-byte read holds its upper nibble.
// - The interval count high register returns the held nibble in bits 3:0 and zero above.
// - The tick, interval and wrap requests carry vectors 0034h, 0038h and 0044h in that priority.
// - The timer runs on its own timer rate, apart from the bus timing.
// - A posted request stays until the CPU takes it or software clears it.
module frit_timer
    import frit_pkg::*;
#(
    parameter int TICK_PERIOD = TICK_TICKS
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire frit_wb_req_t wb_i,
    output frit_wb_rsp_t wb_o,
    input wire logic [2:0] irq_take_i,
    output logic [2:0] irq_req_o,
    output logic [7:0] irq_vec_o
);

    localparam logic [15:0] TICK_MASK = 16'(TICK_PERIOD - 1);

    logic [7:0] acc;
    logic [7:0] next_acc;
    logic [7:0] acc_sum;
    logic tmr_en;
    logic [15:0] free_cnt;
    logic [15:0] next_free_cnt;
    logic [7:0] free_hold_hi;
    logic [7:0] next_free_hold_hi;
    logic [7:0] free_wr_lo;
    logic [7:0] next_free_wr_lo;
    logic [11:0] ivl_cnt;
    logic [11:0] next_ivl_cnt;
    logic [3:0] ivl_hold_hi;
    logic [3:0] next_ivl_hold_hi;
    logic [11:0] reload;
    logic [11:0] next_reload;
    logic [2:0] posted;
    logic [2:0] next_posted;
    logic [7:0] vec;
    logic [7:0] next_vec;
    logic ack;
    logic next_ack;
    logic [31:0] rdat;
    logic [31:0] next_rdat;
    logic req;
    logic wr;
    logic rd;
    logic free_load;
    logic tick_evt;
    logic wrap_evt;
    logic ivl_evt;
    logic [2:0] set_bits;
    logic [2:0] clr_bits;

    // Timer tick divider: a phase accumulator gives an exact 4 MHz average from 125 MHz.
    // The timer side is a clock enable, so no crossing is needed between timer and bus.
    always_comb
    begin
        acc_sum = acc + ACC_STEP;
        tmr_en = (acc_sum >= ACC_MOD);
        next_acc = tmr_en ? acc_sum - ACC_MOD : acc_sum;
    end

    // Bus decode: side effects act at the edge where the request is first seen.
    always_comb
    begin
        req = wb_i.cyc & wb_i.stb & ~ack;
        wr = req & wb_i.we & wb_i.sel[0];
        rd = req & ~wb_i.we;
        next_ack = req;
    end

    // Free-running counter, its read hold and its write hold.
    always_comb
    begin
        free_load = wr & (wb_i.adr == FREE_HIGH_ADR);
        next_free_cnt = free_cnt;
        next_free_hold_hi = free_hold_hi;
        next_free_wr_lo = free_wr_lo;
        if (free_load)
        begin
            next_free_cnt = {wb_i.dat[7:0], free_wr_lo};
        end
        else if (tmr_en)
        begin
            next_free_cnt = free_cnt + 16'h0001;
        end
        if (wr & (wb_i.adr == FREE_LOW_ADR))
        begin
            next_free_wr_lo = wb_i.dat[7:0];
        end
        if (rd & (wb_i.adr == FREE_LOW_ADR))
        begin
            next_free_hold_hi = free_cnt[15:8];
        end
        // A load overrides the tick, so the old count that the load replaces posts no tick or wrap request.
        tick_evt = tmr_en & ~free_load & ((free_cnt & TICK_MASK) == TICK_MASK);
        wrap_evt = tmr_en & ~free_load & (free_cnt == FREE_MAX);
    end

    // Interval timer: counts down per tick and reloads at zero, so the period is reload plus one.
    always_comb
    begin
        ivl_evt = tmr_en & (ivl_cnt == IVL_RST);
        next_ivl_cnt = ivl_cnt;
        next_ivl_hold_hi = ivl_hold_hi;
        next_reload = reload;
        if (ivl_evt)
        begin
            next_ivl_cnt = reload;
        end
        else if (tmr_en)
        begin
            next_ivl_cnt = ivl_cnt - 12'h001;
        end
        if (rd & (wb_i.adr == IVL_CNT_LOW_ADR))
        begin
            next_ivl_hold_hi = ivl_cnt[11:8];
        end
        // Each half of the reload stores on its own write; the low byte is expected first.
        if (wr & (wb_i.adr == IVL_RLD_LOW_ADR))
        begin
            next_reload[7:0] = wb_i.dat[7:0];
        end
        if (wr & (wb_i.adr == IVL_RLD_HIGH_ADR))
        begin
            next_reload[11:8] = wb_i.dat[3:0];
        end
    end

    // Posted requests: a new event wins over a take or a clear in the same cycle.
    always_comb
    begin
        set_bits = 3'h0;
        set_bits[IRQ_TICK] = tick_evt;
        set_bits[IRQ_IVL] = ivl_evt;
        set_bits[IRQ_WRAP] = wrap_evt;
        clr_bits = irq_take_i;
        if (wr & (wb_i.adr == IRQ_STAT_ADR))
        begin
            clr_bits = clr_bits | wb_i.dat[2:0];
        end
        next_posted = (posted & ~clr_bits) | set_bits;
        // Fixed priority: tick first, interval second, wrap last.
        if (next_posted[IRQ_TICK])
        begin
            next_vec = VEC_TICK;
        end
        else if (next_posted[IRQ_IVL])
        begin
            next_vec = VEC_IVL;
        end
        else if (next_posted[IRQ_WRAP])
        begin
            next_vec = VEC_WRAP;
        end
        else
        begin
            next_vec = VEC_NONE;
        end
    end

    // Read data mux; unmapped addresses read zero and are still acknowledged.
    always_comb
    begin
        next_rdat = 32'h0000_0000;
        if (rd)
        begin
            unique case (wb_i.adr)
                FREE_LOW_ADR: next_rdat[7:0] = free_cnt[7:0];
                FREE_HIGH_ADR: next_rdat[7:0] = free_hold_hi;
                IVL_CNT_LOW_ADR: next_rdat[7:0] = ivl_cnt[7:0];
                IVL_CNT_HIGH_ADR: next_rdat[7:0] = {4'h0, ivl_hold_hi};
                IVL_RLD_LOW_ADR: next_rdat[7:0] = reload[7:0];
                IVL_RLD_HIGH_ADR: next_rdat[7:0] = {4'h0, reload[11:8]};
                IRQ_STAT_ADR: next_rdat[7:0] = {5'h00, posted};
                default: next_rdat = 32'h0000_0000;
            endcase
        end
    end

    // State registers.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            acc <= BYTE_RST;
            free_cnt <= FREE_RST;
            free_hold_hi <= BYTE_RST;
            free_wr_lo <= BYTE_RST;
            ivl_cnt <= IVL_RST;
            ivl_hold_hi <= 4'h0;
            reload <= IVL_RST;
            posted <= 3'h0;
            vec <= VEC_NONE;
            ack <= 1'b0;
            rdat <= 32'h0000_0000;
        end
        else
        begin
            acc <= next_acc;
            free_cnt <= next_free_cnt;
            free_hold_hi <= next_free_hold_hi;
            free_wr_lo <= next_free_wr_lo;
            ivl_cnt <= next_ivl_cnt;
            ivl_hold_hi <= next_ivl_hold_hi;
            reload <= next_reload;
            posted <= next_posted;
            vec <= next_vec;
            ack <= next_ack;
            rdat <= next_rdat;
        end
    end

    // Outputs come straight from flip-flops.
    assign wb_o.ack = ack;
    assign wb_o.dat = rdat;
    assign irq_req_o = posted;
    assign irq_vec_o = vec;

    // Checks on the timer and bus behaviour.
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_low_read;
        rd && (wb_i.adr == FREE_LOW_ADR);
    endsequence

    sequence s_high_write;
        wr && (wb_i.adr == FREE_HIGH_ADR);
    endsequence

    sequence s_bus_answer;
        ##1 ack ##1 !ack;
    endsequence

    bus_ack_once_a: assert property (req |-> s_bus_answer)
        else $error("ack not a single cycle after request");

    free_incr_a: assert property (tmr_en && !free_load
        |=> free_cnt == $past(free_cnt) + 16'h0001)
        else $error("free counter did not advance on tick");

    free_hold_a: assert property (s_low_read |=> free_hold_hi == $past(free_cnt[15:8]))
        else $error("high byte not held at low read");

    free_sample_a: assert property (s_low_read |=> rdat[7:0] == $past(free_cnt[7:0]))
        else $error("low byte not sampled at read");

    free_load_a: assert property (s_high_write
        |=> free_cnt == {$past(wb_i.dat[7:0]), $past(free_wr_lo)})
        else $error("counter not loaded at high write");

    tick_post_a: assert property (tick_evt |=> posted[IRQ_TICK] && vec == VEC_TICK)
        else $error("tick request not posted");

    wrap_post_a: assert property (tmr_en && !free_load && free_cnt == FREE_MAX
        |=> free_cnt == FREE_RST && posted[IRQ_WRAP])
        else $error("wrap not posted or counter not zero");

    ivl_reload_a: assert property (ivl_evt
        |=> ivl_cnt == $past(reload) && posted[IRQ_IVL])
        else $error("interval reload or request missing");

    ivl_high_a: assert property (rd && wb_i.adr == IVL_CNT_HIGH_ADR
        |=> rdat[7:0] == {4'h0, $past(ivl_hold_hi)})
        else $error("interval high read wrong");

    ivl_hold_a: assert property (rd && wb_i.adr == IVL_CNT_LOW_ADR
        |=> ivl_hold_hi == $past(ivl_cnt[11:8]))
        else $error("interval nibble not held");

    post_stays_a: assert property (posted[IRQ_WRAP] && !clr_bits[IRQ_WRAP]
        |=> posted[IRQ_WRAP])
        else $error("posted request dropped without clear");

    vec_prio_a: assert property (posted[IRQ_IVL] && !posted[IRQ_TICK] |-> vec == VEC_IVL)
        else $error("vector priority wrong");

    tick_rate_a: assert property (tmr_en
        |=> !tmr_en ##1 !tmr_en ##1 !tmr_en ##1 !tmr_en ##1 !tmr_en)
        else $error("timer tick faster than 4 MHz");

    // Between reloads the interval count steps down by exactly one per tick.
    ivl_count_a: assert property (tmr_en && !ivl_evt
        |=> ivl_cnt == $past(ivl_cnt) - 12'h001)
        else $error("interval count did not step down");

endmodule

`default_nettype wire
